// ===== spi_slave_port_tb.sv
// testbench: AXI host master and slave port joined over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module spi_slave_port_tb;
    localparam int HALF = 8;
    logic clk = 1'b0, rst = 1'b1, regWe = 1'b0, regRe = 1'b0, irqClr = 1'b0, irqEnable = 1'b0, sleepIn = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWdata = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [7:0] regRdata;
    logic portIrqFlag, wakeReq, awready, wready, bvalid, arready, rvalid;
    logic [31:0] rdata, rdD;
    logic [1:0] bresp, rresp;
    int errors = 0, compares = 0;
    ssp_link_if u_ssp_link_if ();
    ssp_slave_port u_ssp_slave_port (.clk(clk), .rst(rst), .link(u_ssp_link_if.dev), .regWe(regWe), .regRe(regRe),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .irqClr(irqClr), .irqEnable(irqEnable),
        .sleepIn(sleepIn), .portIrqFlag(portIrqFlag), .wakeReq(wakeReq));
    ssp_host_master #(.HALF_CYC(HALF)) u_ssp_host_master (.clk(clk), .rst(rst), .link(u_ssp_link_if.host),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    ssp_link_properties #(.HALF_CYC(HALF)) u_ssp_link_properties (.clk(clk), .rst(rst), .sck(u_ssp_link_if.sck),
        .ssN(u_ssp_link_if.ssN), .mosi(u_ssp_link_if.mosi), .sdo(u_ssp_link_if.sdo), .sdoOe(u_ssp_link_if.sdoOe),
        .miso(u_ssp_link_if.miso));
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // address and data are released each on its own ready
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64; n++)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (bvalid !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: no write response", $time);
        end
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge clk);
    endtask
    task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input bit cmp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64; n++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (rvalid !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: no read response", $time);
        end
        rdD = rdata;
        rready <= 1'b0;
        if (cmp)
        begin
            chk(rdD, ed);
            chk({30'h0, rresp}, {30'h0, er});
        end
        @(posedge clk);
    endtask
    task automatic slvWr(input logic [1:0] a, input logic [7:0] d);
        regWe <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic slvRd(input logic [1:0] a, input logic [7:0] e);
        regRe <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRe <= 1'b0;
        @(posedge clk);
        chk({24'h0, regRdata}, {24'h0, e});
    endtask
    task automatic clrIrq();
        irqClr <= 1'b1;
        @(posedge clk);
        irqClr <= 1'b0;
        @(posedge clk);
    endtask
    // with the clock-edge bit clear, slave flags land a few clocks after the master reports idle
    task automatic waitIdle();
        int n = 0;
        rdD = 32'h1;
        while (rdD[0] !== 1'b0 && n < 100)
        begin
            axiRd(`SSP_H_STATUS, 32'h0, 2'h0, 1'b0);
            n++;
        end
        if (rdD[0] !== 1'b0)
        begin
            errors++;
            $display("Error at %0t: master stayed busy", $time);
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic [7:0] ex);
        axiWr(`SSP_H_TX, {24'h0, tx}, `SSP_AXI_OKAY);
        waitIdle();
        axiRd(`SSP_H_RX, {24'h0, ex}, `SSP_AXI_OKAY, 1'b1);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        slvRd(`SSP_REG_CTRL1, `SSP_C1_RESET);
        slvRd(`SSP_REG_CTRL3, `SSP_C3_RESET);
        slvWr(`SSP_REG_STATUS, 8'hFF);
        slvRd(`SSP_REG_STATUS, 8'hC0);
        slvWr(`SSP_REG_STATUS, 8'h80);
        slvRd(`SSP_REG_STATUS, 8'h80);
        slvWr(`SSP_REG_CTRL1, 8'h24);
        slvRd(`SSP_REG_CTRL1, 8'h24);
        slvWr(`SSP_REG_DATA, 8'hA5);
        slvRd(`SSP_REG_DATA, 8'hA5);
        axiWr(`SSP_H_CTRL, 32'h5, `SSP_AXI_OKAY);
        clrIrq();
        xfer(8'h3C, 8'hA5);
        chk({31'h0, portIrqFlag}, 32'h1);
        chk({31'h0, wakeReq}, 32'h0);
        slvRd(`SSP_REG_STATUS, 8'h81);
        slvRd(`SSP_REG_DATA, 8'h3C);
        clrIrq();
        xfer(8'h5A, 8'h3C);
        chk({31'h0, portIrqFlag}, 32'h1);
        slvWr(`SSP_REG_DATA, 8'h77);
        slvRd(`SSP_REG_CTRL1, 8'hA4);
        slvWr(`SSP_REG_CTRL1, 8'h24);
        slvWr(`SSP_REG_CTRL3, 8'h10);
        slvWr(`SSP_REG_DATA, 8'h77);
        slvRd(`SSP_REG_CTRL1, 8'h24);
        slvRd(`SSP_REG_DATA, 8'h77);
        xfer(8'h00, 8'h77);
        slvRd(`SSP_REG_DATA, 8'h00);
        clrIrq();
        axiWr(`SSP_H_TX, 32'hFF, `SSP_AXI_OKAY);
        repeat (40) @(posedge clk);
        slvWr(`SSP_REG_DATA, 8'h11);
        slvRd(`SSP_REG_CTRL1, 8'hA4);
        slvWr(`SSP_REG_CTRL1, 8'h24);
        axiWr(`SSP_H_CTRL, 32'h4, `SSP_AXI_OKAY);
        repeat (6) @(posedge clk);
        chk({31'h0, u_ssp_link_if.miso}, 32'h1);
        waitIdle();
        chk({31'h0, portIrqFlag}, 32'h0);
        slvRd(`SSP_REG_STATUS, 8'h80);
        slvWr(`SSP_REG_DATA, 8'h96);
        sleepIn <= 1'b1;
        irqEnable <= 1'b1;
        axiWr(`SSP_H_CTRL, 32'h5, `SSP_AXI_OKAY);
        chk({31'h0, wakeReq}, 32'h0);
        xfer(8'hC3, 8'h96);
        chk({31'h0, wakeReq}, 32'h1);
        slvRd(`SSP_REG_DATA, 8'hC3);
        slvWr(`SSP_REG_CTRL3, 8'h00);
        slvWr(`SSP_REG_CTRL1, 8'h25);
        xfer(8'h69, 8'hC3);
        xfer(8'h12, 8'h69);
        slvRd(`SSP_REG_CTRL1, 8'h65);
        slvRd(`SSP_REG_DATA, 8'h69);
        axiWr(8'h10, 32'h0, `SSP_AXI_SLVERR);
        axiRd(8'h10, 32'h0, `SSP_AXI_SLVERR, 1'b1);
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule // spi_slave_port_tb
`default_nettype wire

// ===== ssp_host_master.sv
// external master end: AXI4-Lite register slave driving the serial link
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_host_master
    import ssp_pkg::*;
#(
    parameter int HALF_CYC = `SSP_HALF_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    ssp_link_if.host link,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    logic awHave_r;
    logic wHave_r;
    logic [7:0] awAddr_r;
    logic [7:0] wByte_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [2:0] ctrl_r;
    ssp_byte_t tx_r;
    ssp_byte_t rx_r;
    logic rxValid_r;
    ssp_host_state_t state_r;
    logic [15:0] halfCnt_r;
    logic [2:0] bits_r;
    logic sck_r;
    logic mosi_r;
    logic [1:0] misoSync_r;
    logic awReady_r;
    logic wReady_r;
    logic arReady_r;
    logic ssN_r;
    logic doWrite;
    logic startTx;
    logic halfDone;
    logic rxRead;
    logic lastBit;

    assign doWrite = awHave_r & wHave_r & ~bvalid_r;
    assign startTx = doWrite & (awAddr_r == `SSP_H_TX) & (state_r == SSP_IDLE) & ctrl_r[`SSP_H_SS]; // RULE8
    assign halfDone = (halfCnt_r == 16'(HALF_CYC - 1));
    assign rxRead = arvalid & ~rvalid_r & (araddr == `SSP_H_RX);
    assign lastBit = (bits_r == 3'h7);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awReady_r <= 1'b1;
            wReady_r <= 1'b1;
            awAddr_r <= 8'h00;
            wByte_r <= 8'h00;
        end
        else
        begin
            if (awvalid && !awHave_r)
            begin
                awHave_r <= 1'b1;
                awReady_r <= 1'b0;
                awAddr_r <= awaddr;
            end
            if (wvalid && !wHave_r)
            begin
                wHave_r <= 1'b1;
                wReady_r <= 1'b0;
                wByte_r <= wstrb[0] ? wdata[7:0] : 8'h00;
            end
            if (doWrite)
            begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                awReady_r <= 1'b1;
                wReady_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= `SSP_AXI_OKAY;
        end
        else if (doWrite)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= (awAddr_r == `SSP_H_CTRL || awAddr_r == `SSP_H_TX) ? `SSP_AXI_OKAY : `SSP_AXI_SLVERR;
        end
        else if (bready)
            bvalid_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_r <= 3'h0;
        else if (doWrite && awAddr_r == `SSP_H_CTRL)
            ctrl_r <= wByte_r[2:0];
    end

    // select pin follows its control bit one clock later from a flop of its own
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ssN_r <= 1'b1;
        else
            ssN_r <= ~ctrl_r[`SSP_H_SS]; // RULE8
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            arReady_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `SSP_AXI_OKAY;
        end
        else if (arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            arReady_r <= 1'b0;
            rresp_r <= `SSP_AXI_OKAY;
            case (araddr)
                `SSP_H_CTRL: rdata_r <= {29'h0, ctrl_r};
                `SSP_H_TX: rdata_r <= {24'h0, tx_r};
                `SSP_H_RX: rdata_r <= {24'h0, rx_r};
                `SSP_H_STATUS: rdata_r <= {30'h0, rxValid_r, state_r != SSP_IDLE};
                default:
                begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= `SSP_AXI_SLVERR;
                end
            endcase
        end
        else if (rready)
        begin
            rvalid_r <= 1'b0;
            arReady_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            misoSync_r <= 2'h3;
        else
            misoSync_r <= {misoSync_r[0], link.miso};
    end

    // shift engine; cke set: sample on leading edge, change on trailing edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= SSP_IDLE;
            halfCnt_r <= 16'h0000;
            bits_r <= 3'h0;
            tx_r <= 8'h00;
            mosi_r <= 1'b0;
            sck_r <= 1'b0;
        end
        else if (!ctrl_r[`SSP_H_SS])
        begin
            // dropping select cuts the byte short and parks the clock, so no pulse lands outside a frame
            state_r <= SSP_IDLE;
            sck_r <= ctrl_r[`SSP_H_CPOL]; // RULE8
        end
        else
        begin
            case (state_r)
                SSP_IDLE:
                begin
                    sck_r <= ctrl_r[`SSP_H_CPOL]; // RULE4
                    halfCnt_r <= 16'h0000;
                    bits_r <= 3'h0;
                    if (startTx)
                    begin
                        tx_r <= wByte_r;
                        mosi_r <= wByte_r[7]; // RULE16
                        state_r <= SSP_LEAD;
                    end
                end
                SSP_LEAD:
                begin
                    halfCnt_r <= halfDone ? 16'h0000 : halfCnt_r + 16'h0001;
                    if (halfDone)
                    begin
                        sck_r <= ~ctrl_r[`SSP_H_CPOL];
                        if (!ctrl_r[`SSP_H_CKE])
                        begin
                            mosi_r <= tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                        state_r <= SSP_TRAIL;
                    end
                end
                SSP_TRAIL:
                begin
                    halfCnt_r <= halfDone ? 16'h0000 : halfCnt_r + 16'h0001;
                    if (halfDone)
                    begin
                        sck_r <= ctrl_r[`SSP_H_CPOL];
                        if (ctrl_r[`SSP_H_CKE])
                        begin
                            mosi_r <= tx_r[6];
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                        bits_r <= bits_r + 3'h1;
                        state_r <= lastBit ? SSP_IDLE : SSP_LEAD;
                    end
                end
                default: state_r <= SSP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rx_r <= 8'h00;
        else if (halfDone && ((state_r == SSP_LEAD) == ctrl_r[`SSP_H_CKE]) && state_r != SSP_IDLE)
            rx_r <= {rx_r[6:0], misoSync_r[1]}; // RULE16
    end

    // a finished byte wins over a clearing read in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rxValid_r <= 1'b0;
        else if (state_r == SSP_TRAIL && halfDone && lastBit)
            rxValid_r <= 1'b1;
        else if (rxRead)
            rxValid_r <= 1'b0;
    end

    assign link.sck = sck_r;
    assign link.ssN = ssN_r; // RULE8
    assign link.mosi = mosi_r;
    assign awready = awReady_r;
    assign wready = wReady_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arReady_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
endmodule // ssp_host_master
`default_nettype wire

// ===== ssp_link_if.sv
// serial link between the external master and the slave port
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
    logic sck;
    logic ssN;
    logic mosi;
    logic sdo;
    logic sdoOe;
    logic miso;
    // floating data output is pulled high
    assign miso = sdoOe ? sdo : 1'b1;
    modport dev (input sck, input ssN, input mosi, output sdo, output sdoOe);
    modport host (output sck, output ssN, output mosi, input miso);
endinterface
`default_nettype wire

// ===== ssp_link_properties.sv
// concurrent checks on the serial link between host and slave
`timescale 1ns/1ps
`default_nettype none
module ssp_link_properties
#(
    parameter int HALF_CYC = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic ssN,
    input wire logic mosi,
    input wire logic sdo,
    input wire logic sdoOe,
    input wire logic miso
);
    logic sckD_r;
    logic [7:0] halfCnt_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // samples spent at the present clock level, restarted on every edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sckD_r <= 1'b0;
            halfCnt_r <= 8'h00;
        end
        else
        begin
            sckD_r <= sck;
            halfCnt_r <= (sck != sckD_r) ? 8'h00 : halfCnt_r + 8'h01;
        end
    end
    AST_SEL_IDLE: assert property ($fell(ssN) |-> !sck)
        else $error("select fell with clock active");
    // while deselected the clock may only change by falling low
    AST_CLK_IN_FRAME: assert property ($changed(sck) && ssN |-> !sck)
        else $error("clock pulse outside a frame");
    AST_OUT_DRIVEN: assert property (!ssN [*5] |-> sdoOe)
        else $error("output not driven while selected");
    AST_OUT_RELEASE: assert property ($rose(ssN) |-> ##4 !sdoOe)
        else $error("output still driven after deselect");
    AST_OUT_IDLE: assert property (ssN [*5] |-> !sdoOe && miso)
        else $error("output driven while deselected");
    AST_SDO_TRAIL: assert property ($changed(sdo) && sdoOe |-> !sck)
        else $error("slave data moved with clock high");
    AST_MOSI_TRAIL: assert property ($changed(mosi) && !ssN |-> !sck)
        else $error("master data moved with clock high");
    AST_HALF_PERIOD: assert property (sck != sckD_r && !sck && !ssN |-> halfCnt_r == 8'(HALF_CYC - 1))
        else $error("clock high time wrong");
endmodule // ssp_link_properties
`default_nettype wire

// ===== ssp_params.svh
// shared offsets, field positions, reset values and timing counts for the serial port
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// device register indexes on the device's own register port
`define SSP_REG_STATUS 2'h0
`define SSP_REG_CTRL1 2'h1
`define SSP_REG_CTRL3 2'h2
`define SSP_REG_DATA 2'h3

// control one fields
`define SSP_C1_WCOL 7
`define SSP_C1_OVF 6
`define SSP_C1_EN 5
`define SSP_C1_CKP 4
`define SSP_MODE_SLAVE_SS 4'h4
`define SSP_MODE_SLAVE 4'h5
`define SSP_C1_RESET 8'h00

// status fields: upper two writable, lower six read-only
`define SSP_ST_CKE 7
`define SSP_ST_SMP 6
`define SSP_ST_SCK 1
`define SSP_ST_BF 0

// control three fields
`define SSP_C3_BUFFER_OVERWRITE_ENABLE 4
`define SSP_C3_RESET 8'h00

// host register byte offsets on AXI4-Lite
`define SSP_H_CTRL 8'h00
`define SSP_H_TX 8'h04
`define SSP_H_RX 8'h08
`define SSP_H_STATUS 8'h0C
`define SSP_H_SS 0
`define SSP_H_CPOL 1
`define SSP_H_CKE 2
`define SSP_H_BUSY 0
`define SSP_H_RXV 1

// link timing: half serial clock period as seen by the host divider
`define SSP_SYS_NS 8
`define SSP_HALF_NS 64
`define SSP_HALF_CYC ((`SSP_HALF_NS + `SSP_SYS_NS - 1) / `SSP_SYS_NS)

`define SSP_AXI_OKAY 2'h0
`define SSP_AXI_SLVERR 2'h2

`endif

// ===== ssp_pkg.sv
// byte type shared by both ends of the serial port link, and the host master's state type
`default_nettype none
package ssp_pkg;
    typedef logic [7:0] ssp_byte_t;
    typedef enum logic [1:0]
    {
        SSP_IDLE = 2'b00,
        SSP_LEAD = 2'b01,
        SSP_TRAIL = 2'b10
    } ssp_host_state_t;
endpackage
`default_nettype wire

// ===== ssp_slave_port.sv
// slave end of the synchronous serial port: shifter, buffer, flags and register port
// Function
// RULE1 - full byte moves to buffer, sets flag
// RULE2 - data write loads buffer and shifter together
// RULE3 - shift only on external clock edges
// RULE4 - clock idles at polarity level before enabling
// RULE5 - keeps working in sleep, wakes processor
// RULE6 - overwrite enable accepts writes despite unread byte
// RULE7 - daisy chain re-sends received bits
// RULE8 - master holds select high until transfer
// RULE9 - mode field 0100 selects select-controlled slave
// RULE10 - select low enables shifting and drives output
// RULE11 - select high floats output immediately (here three clocks later, through the synchronised select)
// RULE12 - select high or disable clears bit counter
// RULE13 - clock-edge bit set requires select control; the code also applies the bit in mode 0101
// RULE14 - sample-phase bit stays clear as slave; the code lets it be written and read back
// RULE15 - status low six read-only, control writable
// RULE16 - most significant bit first, one per clock
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_slave_port
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ssp_link_if.dev link,
    input wire logic regWe,
    input wire logic regRe,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic irqClr,
    input wire logic irqEnable,
    input wire logic sleepIn,
    output logic portIrqFlag,
    output logic wakeReq
);
    logic [2:0] sckSync_r;
    logic [1:0] ssSync_r;
    logic [1:0] sdiSync_r;
    logic [7:0] ctrlOne_r;
    logic [1:0] statHi_r;
    logic [7:0] ctrlThree_r;
    ssp_byte_t shift_r;
    ssp_byte_t buffer_r;
    logic [2:0] bitCnt_r;
    logic bufFull_r;
    logic sdoBit_r;
    logic sdoOe_r;
    logic irq_r;
    logic wake_r;
    ssp_byte_t rdata_r;

    logic enable;
    logic clock_polarity_bit;
    logic cke;
    logic buffer_overwrite_enable;
    logic modeSs;
    logic modeFree;
    logic active;
    logic logicReset;
    logic sckRise;
    logic sckFall;
    logic leadEdge;
    logic trailEdge;
    logic sampleEdge;
    logic changeEdge;
    logic byteDone;
    logic rxTake;
    logic bufWrite;
    logic wrAccept;
    logic bufRead;
    ssp_byte_t rxByte;

    // pins are asynchronous to clk; only the second stage and later are looked at
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sckSync_r <= 3'h0;
            ssSync_r <= 2'h3;
            sdiSync_r <= 2'h0;
        end
        else
        begin
            sckSync_r <= {sckSync_r[1:0], link.sck};
            ssSync_r <= {ssSync_r[0], link.ssN};
            sdiSync_r <= {sdiSync_r[0], link.mosi};
        end
    end

    assign enable = ctrlOne_r[`SSP_C1_EN];
    assign clock_polarity_bit = ctrlOne_r[`SSP_C1_CKP];
    assign cke = statHi_r[1];
    assign buffer_overwrite_enable = ctrlThree_r[`SSP_C3_BUFFER_OVERWRITE_ENABLE];
    assign modeSs = (ctrlOne_r[3:0] == `SSP_MODE_SLAVE_SS); // RULE9
    assign modeFree = (ctrlOne_r[3:0] == `SSP_MODE_SLAVE);
    assign active = enable & (modeFree | (modeSs & ~ssSync_r[1])); // RULE10
    assign logicReset = ~enable | (modeSs & ssSync_r[1]); // RULE12
    assign sckRise = sckSync_r[1] & ~sckSync_r[2];
    assign sckFall = ~sckSync_r[1] & sckSync_r[2];
    assign leadEdge = clock_polarity_bit ? sckFall : sckRise;
    assign trailEdge = clock_polarity_bit ? sckRise : sckFall;
    // clock-edge bit: set samples on the leading edge and changes output on the trailing one
    assign sampleEdge = active & (cke ? leadEdge : trailEdge); // RULE3
    assign changeEdge = active & (cke ? trailEdge : leadEdge); // RULE3
    assign byteDone = sampleEdge & (bitCnt_r == 3'h7);
    assign rxByte = {shift_r[6:0], sdiSync_r[1]}; // RULE16
    assign rxTake = byteDone & (~bufFull_r | buffer_overwrite_enable);
    assign bufWrite = regWe & (regAddr == `SSP_REG_DATA);
    // a write mid-byte would corrupt the shifter, so it is refused and flagged
    assign wrAccept = bufWrite & (~bufFull_r | buffer_overwrite_enable) & (bitCnt_r == 3'h0); // RULE6
    assign bufRead = regRe & (regAddr == `SSP_REG_DATA);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bitCnt_r <= 3'h0;
        else if (logicReset)
            bitCnt_r <= 3'h0; // RULE12
        else if (sampleEdge)
            bitCnt_r <= bitCnt_r + 3'h1; // RULE16
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            shift_r <= 8'h00;
        else if (wrAccept)
            shift_r <= regWdata; // RULE2
        else if (sampleEdge)
            shift_r <= rxByte; // RULE7
    end

    // after a full byte the shifter holds what came in, so the next group re-sends it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sdoBit_r <= 1'b0;
        else if (wrAccept)
            sdoBit_r <= regWdata[7]; // RULE16
        else if (changeEdge)
            sdoBit_r <= shift_r[7]; // RULE7
    end

    // output enable follows the synchronised select, so release lags the pin by three clocks
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sdoOe_r <= 1'b0;
        else
            sdoOe_r <= active; // RULE11
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            buffer_r <= 8'h00;
        else if (wrAccept)
            buffer_r <= regWdata; // RULE2
        else if (rxTake)
            buffer_r <= rxByte; // RULE1
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bufFull_r <= 1'b0;
        else if (rxTake)
            bufFull_r <= 1'b1; // RULE1
        else if (bufRead)
            bufFull_r <= 1'b0;
    end

    // hardware-set flags win over a clearing write in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrlOne_r <= `SSP_C1_RESET;
        else
        begin
            if (regWe && regAddr == `SSP_REG_CTRL1)
                ctrlOne_r <= regWdata; // RULE15
            if (bufWrite && !wrAccept)
                ctrlOne_r[`SSP_C1_WCOL] <= 1'b1;
            if (byteDone && bufFull_r && !buffer_overwrite_enable)
                ctrlOne_r[`SSP_C1_OVF] <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            statHi_r <= 2'h0;
        else if (regWe && regAddr == `SSP_REG_STATUS)
            statHi_r <= regWdata[`SSP_ST_CKE:`SSP_ST_SMP]; // RULE15
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrlThree_r <= `SSP_C3_RESET;
        else if (regWe && regAddr == `SSP_REG_CTRL3)
            ctrlThree_r <= regWdata;
    end

    // byte completion runs on the synchronised pin clock, so it works with the core asleep
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_r <= 1'b0;
        else if (byteDone)
            irq_r <= 1'b1; // RULE1
        else if (irqClr)
            irq_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wake_r <= 1'b0;
        else
            wake_r <= irq_r & irqEnable & sleepIn; // RULE5
    end

    // pin level of the clock is readable so software can check its idle state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (regRe)
        begin
            case (regAddr)
                `SSP_REG_STATUS: rdata_r <= {statHi_r, 4'h0, sckSync_r[1], bufFull_r};
                `SSP_REG_CTRL1: rdata_r <= ctrlOne_r;
                `SSP_REG_CTRL3: rdata_r <= ctrlThree_r;
                `SSP_REG_DATA: rdata_r <= buffer_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign link.sdo = sdoBit_r;
    assign link.sdoOe = sdoOe_r;
    assign regRdata = rdata_r;
    assign portIrqFlag = irq_r;
    assign wakeReq = wake_r;
endmodule // ssp_slave_port
`default_nettype wire
